// ==== radio_seq_pkg.sv ====
// constants for the radio mode sequencer and frequency correction block
// assumes a 25 MHz core clock and a 32-bit avalon-mm register slave
package radio_seq_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  // register byte offsets
  localparam logic [7:0] OPERATING_MODE_REG_ADDR = 8'h00;
  localparam logic [7:0] CORRECTION_CONTROL_REG_ADDR = 8'h04;
  localparam logic [7:0] CORRECTION_ERROR_CONTROL_REG_ADDR = 8'h08;
  localparam logic [7:0] CORRECTION_BANDWIDTH_REG_ADDR = 8'h0c;
  localparam logic [7:0] CORRECTION_TEST_REG_ADDR = 8'h10;
  localparam logic [7:0] FREQ_ERROR_REG_ADDR = 8'h14;
  localparam logic [7:0] CARRIER_FREQUENCY_LOW_REG_ADDR = 8'h18;
  localparam logic [7:0] TEMP_REG_ADDR = 8'h1c;
  localparam logic [7:0] TIMEOUT_REG_ADDR = 8'h20;
  localparam logic [7:0] STATUS_REG_ADDR = 8'h24;
  localparam logic [7:0] TIMING_REG_ADDR = 8'h28;
  localparam logic [7:0] RX_BW_REG_ADDR = 8'h2c;
  // operating mode register fields
  localparam int MODE_LSB = 2;
  localparam int LISTEN_BIT = 6;
  localparam int BYPASS_BIT = 7;
  // correction error control fields, plus the correction control low index bit
  localparam int LAUNCH_BIT = 2;
  localparam int AUTO_ON_BIT = 3;
  localparam int AUTO_CLEAR_BIT = 4;
  localparam int FREQ_ERR_DONE_BIT = 6;
  localparam int LOW_INDEX_BIT = 5;
  // temp register fields
  localparam int TEMP_LAUNCH_BIT = 8;
  localparam int TEMP_BUSY_BIT = 9;
  // mode encodings
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STANDBY = 3'h1;
  localparam logic [2:0] MODE_SYNTH = 3'h2;
  localparam logic [2:0] MODE_TX = 3'h3;
  localparam logic [2:0] MODE_RX = 3'h4;
  // reset values and the ambient temperature code
  localparam logic [7:0] OPMODE_RESET = 8'h04;
  localparam logic [7:0] RX_BW_RESET = 8'h55;
  localparam logic [7:0] CORR_BW_RESET = 8'h8b;
  localparam logic [15:0] CARRIER_RESET = 16'h0000;
  localparam logic [7:0] TEMP_AMBIENT_CODE = 8'h80;
  // timing
  localparam int unsigned LOW_INDEX_STEP_HZ = 488;
  localparam int unsigned TEMP_MAX_NS = 100000;
  localparam int unsigned TEMP_CYCLES = (TEMP_MAX_NS / 1000) * (CLK_HZ / 1000000) - 1;
  localparam int unsigned FREQ_ERR_BITS = 4;
  localparam int unsigned TIMEOUT_BITS_PER_COUNT = 16;
  localparam int unsigned RX_START_FILTER_DELAYS = 4;
  localparam int unsigned RX_START_DCCUT_DELAYS = 4;
  localparam int unsigned RX_START_RSSI_SAMPLES = 3;
  localparam int unsigned RX_START_CORR_SAMPLES = 2;
  localparam int unsigned RX_START_LOCK_TIMES = 2;
  localparam logic [15:0] BIT_PERIOD_RESET = 16'd20;
  localparam logic [15:0] OSC_WAKE_RESET = 16'd50;
  localparam logic [15:0] SYNTH_WAKE_RESET = 16'd30;
  localparam logic [15:0] TX_START_RESET = 16'd20;
  typedef enum logic [2:0] {
    SEQ_SLEEP = 3'b000,
    SEQ_OSC = 3'b001,
    SEQ_SYNTH = 3'b011,
    SEQ_PA_REG = 3'b010,
    SEQ_PA_RAMP = 3'b110,
    SEQ_ACTIVE = 3'b111
  } seq_state_t;
endpackage

// ==== bit_timer.sv ====
// bit period tick and down counter, reused by several timers
// assumes same clock domain as the caller
`timescale 1ns/1ps
`default_nettype none
module bit_timer
  import radio_seq_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // control
  input wire logic load_i,
  input wire logic [19:0] count_i,
  input wire logic [15:0] period_i,
  input wire logic tick_mode_i,
  // status
  output logic done_o,
  output logic busy_o
);
  logic [15:0] div;
  logic [19:0] left;
  logic step;
  assign step = tick_mode_i ? (div == 16'h0000) : 1'b1;
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i || load_i || div == 16'h0000) begin
      div <= period_i;
    end else begin
      div <= div - 16'h0001;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      left <= 20'h00000;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else if (load_i) begin
      left <= count_i;
      busy_o <= 1'b1;
      done_o <= 1'b0;
    end else if (busy_o && step) begin
      if (left <= 20'h00001) begin
        busy_o <= 1'b0;
        done_o <= 1'b1;
      end else begin
        left <= left - 20'h00001;
      end
    end else begin
      done_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== radio_mode_sequencer_afc.sv ====
// mode sequencer, frequency correction, temperature and receive timeout control
// assumes a synchronous avalon-mm master and analogue status pins from the radio core
//
// Summary of operation
// - finished correction subtracts the correction result from carrier frequency
// - auto correction on: run correction every time receiver is enabled
// - auto correction off: run only when host sets correction launch bit
// - auto clear on: discard previous correction before evaluating, else keep it; the code clears only when auto correction is also on
// - correction phase uses the alternate correction bandwidth setting
// - low index offset equals field times 488 Hz
// - low index on: correct by frequency error plus offset
// - low index startup: front end plus 4 filter, 4 dc, 3 rssi, 2 corr, 2 lock
// - temperature measurement accepted only in standby or synthesizer mode
// - temperature result falls one step per degree rise
// - temperature measurement finishes and clears busy within 100 us
// - no threshold after rx start count times 16 bits raises timeout
// - after threshold, post detect count times 16 bits raises timeout
// - mode field selects sleep, standby, synth, tx, rx with listed blocks
// - listen enable forces listen mode regardless of mode field
// - sequencer wakes blocks in order unless bypass bit set
// - sleep to tx passes standby with oscillator, synth, waits lock
// - tx entry: amplifier regulator, then ramp, then bit clock output
// - synthesizer lock indicator driven on a pin
// - tx wake time is osc wake plus wait for lock plus tx start, minus skipped terms
// - frequency error takes four bits and stores a signed result
//
// Local design decisions: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module radio_mode_sequencer_afc
  import radio_seq_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // avalon-mm slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // radio core status
  input wire logic pll_locked_i,
  input wire logic signal_threshold_flag_i,
  input wire logic [7:0] freq_error_sample_i,
  input wire logic [7:0] temp_sensor_i,
  // radio core controls
  output logic osc_en_o,
  output logic synth_en_o,
  output logic tx_en_o,
  output logic rx_en_o,
  output logic listen_active_o,
  output logic pa_reg_en_o,
  output logic pa_ramp_o,
  output logic tx_bit_clock_out_o,
  output logic [7:0] channel_bw_o,
  output logic [15:0] carrier_frequency_o,
  output logic pll_lock_pin_o,
  output logic rx_timeout_o
);
  // synchronised pins
  logic lock_s1, lock_s2, thr_s1, thr_s2;
  // registers
  logic [7:0] operating_mode_reg, correction_bandwidth_reg, rx_bw;
  logic [7:0] correction_test_reg, freq_error_reg, temp_value;
  logic [15:0] carrier_frequency_low_reg, correction_result;
  logic [7:0] rx_start_timeout_count, post_detect_timeout_count;
  logic [15:0] bit_period, osc_wake_time, synth_wake_time, transmitter_start_time;
  logic auto_correction_enable, auto_clear_enable, low_index_correction_enable;
  logic correction_busy, freq_error_done, temp_in_progress;
  logic [2:0] mode;
  logic sequencer_bypass, periodic_listen_enable;
  seq_state_t state, next_state;
  logic [2:0] active_mode;
  logic rx_on, rx_on_d;
  logic wr, rd;
  logic [19:0] next_wait;
  logic wait_load, wait_busy;
  logic corr_load, corr_done, corr_busy;
  logic to_load, to_done, to_busy, post_phase;
  logic [7:0] temp_count;
  logic [19:0] startup_bits;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  assign mode = operating_mode_reg[MODE_LSB +: 3];
  assign periodic_listen_enable = operating_mode_reg[LISTEN_BIT];
  assign sequencer_bypass = operating_mode_reg[BYPASS_BIT];
  assign wr = avs_write_i && !avs_waitrequest_o;
  assign rd = avs_read_i && avs_waitrequest_o;

  // pin synchronisers
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      lock_s1 <= 1'b0;
      lock_s2 <= 1'b0;
      thr_s1 <= 1'b0;
      thr_s2 <= 1'b0;
    end else begin
      lock_s1 <= pll_locked_i;
      lock_s2 <= lock_s1;
      thr_s1 <= signal_threshold_flag_i;
      thr_s2 <= thr_s1;
    end
  end

  // one wait state per access
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !(avs_waitrequest_o && (avs_read_i || avs_write_i));
    end
  end

  // configuration writes
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      operating_mode_reg <= OPMODE_RESET;
      auto_correction_enable <= 1'b0;
      auto_clear_enable <= 1'b0;
      low_index_correction_enable <= 1'b0;
      correction_bandwidth_reg <= CORR_BW_RESET;
      rx_bw <= RX_BW_RESET;
      correction_test_reg <= 8'h00;
      rx_start_timeout_count <= 8'h00;
      post_detect_timeout_count <= 8'h00;
      bit_period <= BIT_PERIOD_RESET;
      osc_wake_time <= OSC_WAKE_RESET;
      synth_wake_time <= SYNTH_WAKE_RESET;
      transmitter_start_time <= TX_START_RESET;
    end else if (wr) begin
      if (hit(avs_address_i, OPERATING_MODE_REG_ADDR)) begin
        operating_mode_reg <= avs_writedata_i[7:0];
      end else if (hit(avs_address_i, CORRECTION_CONTROL_REG_ADDR)) begin
        low_index_correction_enable <= avs_writedata_i[LOW_INDEX_BIT];
      end else if (hit(avs_address_i, CORRECTION_ERROR_CONTROL_REG_ADDR)) begin
        auto_correction_enable <= avs_writedata_i[AUTO_ON_BIT];
        auto_clear_enable <= avs_writedata_i[AUTO_CLEAR_BIT];
      end else if (hit(avs_address_i, CORRECTION_BANDWIDTH_REG_ADDR)) begin
        correction_bandwidth_reg <= avs_writedata_i[7:0];
      end else if (hit(avs_address_i, CORRECTION_TEST_REG_ADDR)) begin
        correction_test_reg <= avs_writedata_i[7:0];
      end else if (hit(avs_address_i, TIMEOUT_REG_ADDR)) begin
        rx_start_timeout_count <= avs_writedata_i[7:0];
        post_detect_timeout_count <= avs_writedata_i[15:8];
      end else if (hit(avs_address_i, TIMING_REG_ADDR)) begin
        osc_wake_time <= avs_writedata_i[15:0];
        synth_wake_time <= avs_writedata_i[31:16];
      end else if (hit(avs_address_i, RX_BW_REG_ADDR)) begin
        rx_bw <= avs_writedata_i[7:0];
        bit_period <= avs_writedata_i[23:8];
        transmitter_start_time <= {8'h00, avs_writedata_i[31:24]};
      end
    end
  end

  // register reads, loaded in the wait cycle so data stands at acceptance
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (rd) begin
      if (hit(avs_address_i, OPERATING_MODE_REG_ADDR)) begin
        avs_readdata_o <= {24'h000000, operating_mode_reg};
      end else if (hit(avs_address_i, CORRECTION_CONTROL_REG_ADDR)) begin
        avs_readdata_o <= {26'h0000000, low_index_correction_enable, 5'h00};
      end else if (hit(avs_address_i, CORRECTION_ERROR_CONTROL_REG_ADDR)) begin
        avs_readdata_o <= {25'h0000000, freq_error_done, 1'b0, auto_clear_enable,
                           auto_correction_enable, correction_busy, 2'h0};
      end else if (hit(avs_address_i, CORRECTION_BANDWIDTH_REG_ADDR)) begin
        avs_readdata_o <= {24'h000000, correction_bandwidth_reg};
      end else if (hit(avs_address_i, CORRECTION_TEST_REG_ADDR)) begin
        avs_readdata_o <= {24'h000000, correction_test_reg};
      end else if (hit(avs_address_i, FREQ_ERROR_REG_ADDR)) begin
        avs_readdata_o <= {correction_result, 8'h00, freq_error_reg};
      end else if (hit(avs_address_i, CARRIER_FREQUENCY_LOW_REG_ADDR)) begin
        avs_readdata_o <= {16'h0000, carrier_frequency_low_reg};
      end else if (hit(avs_address_i, TEMP_REG_ADDR)) begin
        avs_readdata_o <= {22'h000000, temp_in_progress, 1'b0, temp_value};
      end else if (hit(avs_address_i, TIMEOUT_REG_ADDR)) begin
        avs_readdata_o <= {16'h0000, post_detect_timeout_count, rx_start_timeout_count};
      end else if (hit(avs_address_i, STATUS_REG_ADDR)) begin
        avs_readdata_o <= {23'h000000, rx_timeout_o, 1'b0, state, active_mode, lock_s2};
      end else if (hit(avs_address_i, TIMING_REG_ADDR)) begin
        avs_readdata_o <= {synth_wake_time, osc_wake_time};
      end else if (hit(avs_address_i, RX_BW_REG_ADDR)) begin
        avs_readdata_o <= {transmitter_start_time[7:0], bit_period, rx_bw};
      end else begin
        avs_readdata_o <= 32'h00000000;
      end
    end
  end

  // wake-up sequencer
  always_comb begin
    next_state = state;
    wait_load = 1'b0;
    next_wait = 20'h00000;
    case (state)
      SEQ_SLEEP: begin
        if (periodic_listen_enable || mode != MODE_SLEEP) begin
          next_state = SEQ_OSC;
          wait_load = 1'b1;
          next_wait = {4'h0, osc_wake_time};
        end
      end
      SEQ_OSC: begin
        if (!wait_busy && !wait_load) begin
          if (mode == MODE_SLEEP && !periodic_listen_enable) begin
            next_state = SEQ_SLEEP;
          end else if (mode == MODE_STANDBY || periodic_listen_enable) begin
            next_state = SEQ_ACTIVE;
          end else begin
            next_state = SEQ_SYNTH;
          end
        end
      end
      SEQ_SYNTH: begin
        if (lock_s2) begin
          if (mode == MODE_TX) begin
            next_state = SEQ_PA_REG;
            wait_load = 1'b1;
            next_wait = {5'h00, transmitter_start_time[15:1]};
          end else begin
            next_state = SEQ_ACTIVE;
          end
        end
      end
      SEQ_PA_REG: begin
        if (!wait_busy) begin
          next_state = SEQ_PA_RAMP;
          wait_load = 1'b1;
          next_wait = {4'h0, transmitter_start_time - {1'b0, transmitter_start_time[15:1]}};
        end
      end
      SEQ_PA_RAMP: begin
        if (!wait_busy && !wait_load) begin
          next_state = SEQ_ACTIVE;
        end
      end
      default: begin
        next_state = SEQ_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state <= SEQ_SLEEP;
      active_mode <= MODE_SLEEP;
    end else if (sequencer_bypass) begin
      state <= SEQ_ACTIVE;
      active_mode <= mode;
    end else if (state == SEQ_ACTIVE && (mode != active_mode)) begin
      // restart from the deepest block still needed, skipping running ones
      if (mode == MODE_SLEEP) begin
        state <= SEQ_SLEEP;
      end else if (active_mode == MODE_SLEEP) begin
        state <= SEQ_SLEEP;
      end else if (mode == MODE_STANDBY) begin
        state <= SEQ_ACTIVE;
      end else begin
        state <= SEQ_SYNTH;
      end
      active_mode <= (mode == MODE_STANDBY || mode == MODE_SLEEP) ? mode : active_mode;
    end else begin
      state <= next_state;
      if (next_state == SEQ_ACTIVE) begin
        active_mode <= mode;
      end
    end
  end

  bit_timer wait_timer (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .load_i(wait_load),
    .count_i(next_wait),
    .period_i(bit_period),
    .tick_mode_i(1'b0),
    .done_o(),
    .busy_o(wait_busy)
  );

  // block enables per mode
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      osc_en_o <= 1'b0;
      synth_en_o <= 1'b0;
      tx_en_o <= 1'b0;
      rx_en_o <= 1'b0;
      listen_active_o <= 1'b0;
      pa_reg_en_o <= 1'b0;
      pa_ramp_o <= 1'b0;
      tx_bit_clock_out_o <= 1'b0;
      pll_lock_pin_o <= 1'b0;
    end else begin
      listen_active_o <= periodic_listen_enable;
      osc_en_o <= !periodic_listen_enable && state != SEQ_SLEEP &&
        !(state == SEQ_ACTIVE && active_mode == MODE_SLEEP);
      synth_en_o <= !periodic_listen_enable && (state == SEQ_SYNTH || state == SEQ_PA_REG ||
                    state == SEQ_PA_RAMP || (state == SEQ_ACTIVE && active_mode >= MODE_SYNTH));
      tx_en_o <= !periodic_listen_enable && state == SEQ_ACTIVE && active_mode == MODE_TX;
      rx_en_o <= rx_on;
      pa_reg_en_o <= !periodic_listen_enable && (state == SEQ_PA_REG || state == SEQ_PA_RAMP ||
                     (state == SEQ_ACTIVE && active_mode == MODE_TX));
      pa_ramp_o <= !periodic_listen_enable && state == SEQ_PA_RAMP;
      tx_bit_clock_out_o <= tx_en_o && !periodic_listen_enable && state == SEQ_ACTIVE &&
        active_mode == MODE_TX && !to_busy && !tx_bit_clock_out_o;
      pll_lock_pin_o <= lock_s2;
    end
  end
  assign rx_on = !periodic_listen_enable && state == SEQ_ACTIVE && active_mode == MODE_RX;

  // frequency correction: error sample over four bits, then subtract
  assign startup_bits = low_index_correction_enable ?
    20'(FREQ_ERR_BITS * RX_START_CORR_SAMPLES + RX_START_FILTER_DELAYS + RX_START_DCCUT_DELAYS +
        RX_START_RSSI_SAMPLES + RX_START_LOCK_TIMES) : 20'(FREQ_ERR_BITS);
  assign corr_load = !corr_busy &&
    ((auto_correction_enable && rx_on && !rx_on_d) ||
     (!auto_correction_enable && wr && hit(avs_address_i, CORRECTION_ERROR_CONTROL_REG_ADDR) &&
      avs_writedata_i[LAUNCH_BIT]));

  bit_timer corr_timer (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .load_i(corr_load),
    .count_i(startup_bits),
    .period_i(bit_period),
    .tick_mode_i(1'b1),
    .done_o(corr_done),
    .busy_o(corr_busy)
  );

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      correction_busy <= 1'b0;
      freq_error_done <= 1'b0;
      freq_error_reg <= 8'h00;
      correction_result <= 16'h0000;
      carrier_frequency_low_reg <= CARRIER_RESET;
      rx_on_d <= 1'b0;
    end else begin
      rx_on_d <= rx_on;
      correction_busy <= corr_busy;
      if (corr_load && auto_correction_enable && auto_clear_enable) begin
        carrier_frequency_low_reg <= carrier_frequency_low_reg + correction_result;
        correction_result <= 16'h0000;
      end else if (corr_done) begin
        freq_error_reg <= freq_error_sample_i;
        freq_error_done <= 1'b1;
        // offset in 488 hz steps folded with the signed error
        correction_result <= {{8{freq_error_sample_i[7]}}, freq_error_sample_i} +
          (low_index_correction_enable ? {8'h00, correction_test_reg} : 16'h0000);
        carrier_frequency_low_reg <= carrier_frequency_low_reg -
          ({{8{freq_error_sample_i[7]}}, freq_error_sample_i} +
           (low_index_correction_enable ? {8'h00, correction_test_reg} : 16'h0000));
      end else if (wr && hit(avs_address_i, CARRIER_FREQUENCY_LOW_REG_ADDR)) begin
        carrier_frequency_low_reg <= avs_writedata_i[15:0];
      end
      if (corr_load && !corr_done) begin
        freq_error_done <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      channel_bw_o <= RX_BW_RESET;
      carrier_frequency_o <= CARRIER_RESET;
    end else begin
      channel_bw_o <= corr_busy ? correction_bandwidth_reg : rx_bw;
      carrier_frequency_o <= carrier_frequency_low_reg;
    end
  end

  // temperature measurement
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      temp_in_progress <= 1'b0;
      temp_count <= 8'h00;
      temp_value <= 8'h00;
    end else if (temp_in_progress) begin
      if (temp_count == 8'h00) begin
        temp_in_progress <= 1'b0;
        temp_value <= TEMP_AMBIENT_CODE - temp_sensor_i;
      end else begin
        temp_count <= temp_count - 8'h01;
      end
    end else if (wr && hit(avs_address_i, TEMP_REG_ADDR) && avs_writedata_i[TEMP_LAUNCH_BIT] &&
                 state == SEQ_ACTIVE && !periodic_listen_enable &&
                 (active_mode == MODE_STANDBY || active_mode == MODE_SYNTH)) begin
      temp_in_progress <= 1'b1;
      temp_count <= 8'(TEMP_CYCLES - 1);
    end
  end

  // receive timeout
  assign to_load = (rx_on && !rx_on_d) || (rx_on && post_phase == 1'b0 && thr_s2);
  bit_timer to_timer (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .load_i(to_load),
    .count_i(post_phase || thr_s2 ?
             20'(post_detect_timeout_count) * 20'(TIMEOUT_BITS_PER_COUNT) :
             20'(rx_start_timeout_count) * 20'(TIMEOUT_BITS_PER_COUNT)),
    .period_i(bit_period),
    .tick_mode_i(1'b1),
    .done_o(to_done),
    .busy_o(to_busy)
  );

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      post_phase <= 1'b0;
      rx_timeout_o <= 1'b0;
    end else if (!rx_on) begin
      post_phase <= 1'b0;
      rx_timeout_o <= 1'b0;
    end else begin
      if (thr_s2 && !post_phase && !rx_on_d == 1'b0) begin
        post_phase <= 1'b1;
      end
      if (to_done) begin
        rx_timeout_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== radio_core_model.sv ====
// radio core stand-in: lock, threshold, error and sensor levels
// assumes the bench drives the threshold request
`timescale 1ns/1ps
`default_nettype none
module radio_core_model (
  // clock and core controls
  input wire logic clk_i,
  input wire logic synth_en_i,
  input wire logic thr_i,
  // status back to the block
  output logic locked_o,
  output logic thr_o,
  output logic [7:0] err_o,
  output logic [7:0] temp_o
);
  logic [3:0] cnt = 4'h0;
  // lock comes a while after synth enable
  always_ff @(posedge clk_i) begin
    if (!synth_en_i) cnt <= 4'h0;
    else if (cnt != 4'hf) cnt <= cnt + 4'h1;
  end
  assign locked_o = (cnt == 4'hf);
  assign thr_o = thr_i;
  assign err_o = 8'h05;
  assign temp_o = 8'h80;
endmodule
`default_nettype wire

// ==== radio_seq_assertions.sv ====
// port checks for the mode sequencer
// assumes it is bound to the block's top module
`timescale 1ns/1ps
`default_nettype none
module radio_seq_checker (
  input wire logic core_clk_i, rstn_i, avs_read_i, avs_write_i, avs_waitrequest_o,
  input wire logic pll_locked_i, synth_en_o, tx_en_o, rx_en_o, pa_reg_en_o,
  input wire logic pa_ramp_o, tx_bit_clock_out_o, pll_lock_pin_o, rx_timeout_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  property p_lock; pll_locked_i [*3] |-> ##[0:3] pll_lock_pin_o; endproperty
  a_lock: assert property (p_lock) else $error("lock pin late");
  property p_ramp; $rose(pa_ramp_o) |-> pa_reg_en_o; endproperty
  a_ramp: assert property (p_ramp) else $error("ramp before regulator");
  property p_tx_bit_clock_out; $rose(tx_bit_clock_out_o) |-> pa_reg_en_o; endproperty
  a_tx_bit_clock_out: assert property (p_tx_bit_clock_out) else $error("bit clock early");
  property p_txs; tx_en_o |-> synth_en_o; endproperty
  a_txs: assert property (p_txs) else $error("tx without synth");
  property p_rxs; rx_en_o |-> synth_en_o; endproperty
  a_rxs: assert property (p_rxs) else $error("rx without synth");
  property p_excl; !(tx_en_o && rx_en_o); endproperty
  a_excl: assert property (p_excl) else $error("tx and rx together");
  property p_tor; $rose(rx_timeout_o) |-> rx_en_o; endproperty
  a_tor: assert property (p_tor) else $error("timeout outside rx");
  property p_tof; rx_timeout_o && !rx_en_o |-> ##[0:2] !rx_timeout_o; endproperty
  a_tof: assert property (p_tof) else $error("timeout not cleared");
  property p_wr; $rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o; endproperty
  a_wr: assert property (p_wr) else $error("waitrequest late");
  c_tx: cover property ($rose(tx_en_o));
  c_to: cover property ($rose(rx_timeout_o));
  c_lk: cover property ($rose(pll_lock_pin_o));
endmodule
bind radio_mode_sequencer_afc radio_seq_checker radio_seq_checker_inst (.core_clk_i, .rstn_i,
  .avs_read_i, .avs_write_i, .avs_waitrequest_o, .pll_locked_i, .synth_en_o, .tx_en_o,
  .rx_en_o, .pa_reg_en_o, .pa_ramp_o, .tx_bit_clock_out_o, .pll_lock_pin_o, .rx_timeout_o);
`default_nettype wire

// ==== radio_mode_sequencer_afc_tb.sv ====
// bench for the mode sequencer and correction block
// assumes the radio core model on the status side
`timescale 1ns/1ps
`default_nettype none
module radio_mode_sequencer_afc_tb;
  import radio_seq_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, thr = 1'b0, lk, th;
  logic [7:0] a = 8'h00, er, tp, bw;
  logic [31:0] wd = 32'h0, rdat, q;
  logic wq, osc, syn, tx, rx, lst, prg, prp, tx_bit_clock_out, lpin, tmo;
  logic [15:0] car;
  int miscompares = 0, total_checks = 0, n;
  radio_core_model radio_core_model_inst (.clk_i(clk), .synth_en_i(syn), .thr_i(thr),
    .locked_o(lk), .thr_o(th), .err_o(er), .temp_o(tp));
  radio_mode_sequencer_afc radio_mode_sequencer_afc_inst (.core_clk_i(clk), .rstn_i(rstn),
    .avs_address_i(a), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wq), .pll_locked_i(lk),
    .signal_threshold_flag_i(th), .freq_error_sample_i(er), .temp_sensor_i(tp),
    .osc_en_o(osc), .synth_en_o(syn), .tx_en_o(tx), .rx_en_o(rx), .listen_active_o(lst),
    .pa_reg_en_o(prg), .pa_ramp_o(prp), .tx_bit_clock_out_o(tx_bit_clock_out), .channel_bw_o(bw),
    .carrier_frequency_o(car), .pll_lock_pin_o(lpin), .rx_timeout_o(tmo));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic summarize();
    if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int k;
    k = 0;
    a <= ad;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      k++;
    end while (wq !== 1'b0 && k < 50);
    rd <= 1'b0;
    wr <= 1'b0;
    q = rdat;
    @(posedge clk);
  endtask
  task automatic wait_for(input logic [2:0] e);
    n = 0;
    while ({syn, tx, rx} !== e && n < 600) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic t_modes();
    logic [2:0] ex [5] = '{3'h0, 3'h0, 3'h4, 3'h6, 3'h5};
    for (int m = 0; m < 5; m++) begin
      bus(1'b1, OPERATING_MODE_REG_ADDR, 32'h80 | (m << MODE_LSB));
      wait_for(ex[m]);
      chk("enables", {29'h0, ex[m]}, {29'h0, syn, tx, rx});
    end
    bus(1'b1, OPERATING_MODE_REG_ADDR, 32'h4c);
    repeat (10) @(posedge clk);
    chk("listen", 32'h1, {31'h0, lst});
    bus(1'b1, OPERATING_MODE_REG_ADDR, 32'h80);
    bus(1'b1, OPERATING_MODE_REG_ADDR, 32'h0c);
    wait_for(3'h6);
    chk("tx lock", 32'h3, {30'h0, lpin, osc});
  endtask
  task automatic t_temp();
    bus(1'b1, OPERATING_MODE_REG_ADDR, 32'h84);
    bus(1'b1, TEMP_REG_ADDR, 32'h100);
    n = 0;
    do begin
      bus(1'b0, TEMP_REG_ADDR, 32'h0);
      n++;
    end while (q[TEMP_BUSY_BIT] !== 1'b0 && n < 900);
    chk("temp time", 32'h1, {31'h0, n * 3 < 2500});
    bus(1'b1, OPERATING_MODE_REG_ADDR, 32'h80);
    bus(1'b1, TEMP_REG_ADDR, 32'h100);
    bus(1'b0, TEMP_REG_ADDR, 32'h0);
    chk("temp sleep", 32'h0, {31'h0, q[TEMP_BUSY_BIT]});
  endtask
  task automatic t_timeout();
    for (int p = 0; p < 2; p++) begin
      thr <= p[0];
      bus(1'b1, TIMEOUT_REG_ADDR, p ? 32'h108 : 32'h1);
      bus(1'b1, OPERATING_MODE_REG_ADDR, 32'h90);
      wait_for(3'h5);
      n = 0;
      while (tmo !== 1'b1 && n < 900) begin
        @(posedge clk);
        n++;
      end
      chk("timeout span", 32'h1, {31'h0, n > 300 && n < 345});
      bus(1'b1, OPERATING_MODE_REG_ADDR, 32'h84);
      repeat (3) @(posedge clk);
      chk("timeout clear", 32'h0, {31'h0, tmo});
    end
    thr <= 1'b0;
  endtask
  task automatic t_corr();
    bus(1'b1, TIMEOUT_REG_ADDR, 32'h0);
    bus(1'b1, OPERATING_MODE_REG_ADDR, 32'h90);
    wait_for(3'h5);
    chk("no auto", {16'h0, CARRIER_RESET}, {16'h0, car});
    bus(1'b1, CORRECTION_ERROR_CONTROL_REG_ADDR, 32'h4);
    @(posedge clk);
    chk("corr bw", {24'h0, CORR_BW_RESET}, {24'h0, bw});
    n = 0;
    do begin
      bus(1'b0, CORRECTION_ERROR_CONTROL_REG_ADDR, 32'h0);
      n++;
    end while (q[FREQ_ERR_DONE_BIT] !== 1'b1 && n < 200);
    chk("carrier", {16'h0, CARRIER_RESET - 16'h5}, {16'h0, car});
    bus(1'b0, FREQ_ERROR_REG_ADDR, 32'h0);
    chk("freq err", 32'h5, {24'h0, q[7:0]});
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk("bw reset", {24'h0, RX_BW_RESET}, {24'h0, bw});
    bus(1'b0, OPERATING_MODE_REG_ADDR, 32'h0);
    chk("opmode reset", {24'h0, OPMODE_RESET}, q);
    bus(1'b0, 8'hfc, 32'h0);
    chk("unmapped", 32'h0, q);
    t_modes();
    t_temp();
    t_timeout();
    t_corr();
    summarize();
  end
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    summarize();
  end
endmodule
`default_nettype wire
